// >>> src/fcp_coding_path.sv
// 100 Mb/s coding path: strap capture, transmit coder and receive decoder
`timescale 1ns/10ps
// Functional notes
// - serialise MII nibbles at the 125 MHz bit rate
// - 4B/5B encode, then scramble transmit stream
// - scrambled NRZ to NRZI, then MLT-3 line levels
// - sliced MLT-3 levels back to NRZI
// - recover bit timing from NRZI edges
// - recovered timing turns NRZI into NRZ
// - descramble first, then 4B/5B decode
// - decoded groups become MII receive nibbles
// - slicer threshold tracks signal peak adaptively
// - ref clock strap enables reference clock output
// - indicator strap: 1 single, 0 dual
// - mode strap selects MII, NAND tree, power-down
// - straps captured on reset release edge
// - 11-bit LFSR, 2047 sequence, both directions
module fcp_coding_path
  import fcp_pkg::*;
#(
  parameter int SAMPLE_W = 8
) (
  input wire logic clk, // system clock, 200 MHz
  input wire logic rst, // synchronous reset, active high
  input wire logic [3:0] mode_strap, // operating mode strap pins
  input wire logic ref_clock_output_strap, // reference clock enable strap
  input wire logic indicator_style_strap, // indicator style strap
  input wire logic mii_tx_en, // transmit enable from the MAC
  input wire logic [3:0] mii_txd, // transmit nibble from the MAC
  input wire logic mii_tx_er, // transmit error from the MAC
  input wire logic [SAMPLE_W-1:0] line_rx_sample, // equalised line sample, signed
  output logic mii_tx_take, // pulse: transmit nibble taken
  output logic mii_rx_valid, // pulse: new receive nibble
  output logic mii_rx_dv, // receive data valid
  output logic [3:0] mii_rxd, // receive nibble
  output logic mii_rx_er, // receive error
  output logic line_tx_pos, // MLT-3 positive level
  output logic line_tx_neg, // MLT-3 negative level
  output logic ref_clock_output_pin, // 125 MHz bit-rate marker to the MAC
  output logic mode_mii, // captured mode is MII
  output logic mode_nand_tree, // captured mode is NAND tree
  output logic mode_power_down, // captured mode is chip power-down
  output logic single_indicator_style_strap, // captured indicator style
  output logic rx_locked // descrambler locked
);

  // ==========================================================================
  // strap capture
  // ==========================================================================
  logic [5:0] strap_s1_q;
  logic [5:0] strap_s2_q;
  logic rst_q;
  logic [3:0] mode_q;
  logic ref_en_q;
  logic single_led_q;
  logic release_w;
  logic active_w;

  // synchronisers run free: reset must not blank the levels being caught
  always_ff @(posedge clk) begin
    strap_s1_q <= {mode_strap, ref_clock_output_strap, indicator_style_strap};
    strap_s2_q <= strap_s1_q;
    rst_q <= rst;
  end

  assign release_w = rst_q && !rst; // first edge after reset drops
  assign active_w = (mode_q == MODE_MII); // datapath only runs in MII mode

  // latch straps once per reset release
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_q <= MODE_RESET;
      ref_en_q <= 1'b0;
      single_led_q <= 1'b0;
    end else if (release_w) begin
      mode_q <= strap_s2_q[5:2];
      ref_en_q <= strap_s2_q[1];
      single_led_q <= strap_s2_q[0];
    end
  end

  // ==========================================================================
  // transmit bit timing
  // ==========================================================================
  logic [PH_W-1:0] tx_ph_q;
  logic [PH_W:0] tx_sum_w;
  logic tx_tick_w;
  logic [2:0] tx_cnt_q;
  logic tx_load_w;

  assign tx_sum_w = {1'b0, tx_ph_q} + BIT_STEP;
  assign tx_tick_w = tx_sum_w[PH_W] && active_w; // 5 of every 8 clocks
  assign tx_load_w = tx_tick_w && (tx_cnt_q == GROUP_LAST);

  // fractional divider and bit counter within the code group
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_ph_q <= '0;
      tx_cnt_q <= '0;
    end else begin
      tx_ph_q <= tx_sum_w[PH_W-1:0]; // free-running: ref marker must not depend on mode
      if (tx_tick_w) begin
        tx_cnt_q <= (tx_cnt_q == GROUP_LAST) ? 3'h0 : tx_cnt_q + 3'h1;
      end
    end
  end

  // ==========================================================================
  // transmit encoder
  // ==========================================================================
  fcp_tx_state_t tx_st_q;
  fcp_tx_state_t tx_st_d;
  logic [4:0] tx_code_d;
  logic [4:0] tx_sh_q;

  // first two preamble nibbles become J and K; frame end adds T and R
  always_comb begin
    tx_st_d = tx_st_q;
    tx_code_d = CG_I;
    case (tx_st_q)
      FCP_TX_IDLE: begin
        if (mii_tx_en) begin
          tx_code_d = CG_J;
          tx_st_d = FCP_TX_K;
        end
      end
      FCP_TX_K: begin
        tx_code_d = CG_K;
        tx_st_d = FCP_TX_DATA;
      end
      FCP_TX_DATA: begin
        if (!mii_tx_en) begin
          tx_code_d = CG_T;
          tx_st_d = FCP_TX_R;
        end else begin
          tx_code_d = mii_tx_er ? CG_H : fcp_enc(mii_txd);
        end
      end
      FCP_TX_R: begin
        tx_code_d = CG_R;
        tx_st_d = FCP_TX_IDLE;
      end
      default: begin
        tx_st_d = FCP_TX_IDLE;
      end
    endcase
  end

  // group load at the last bit, shift out leftmost bit first
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_st_q <= FCP_TX_IDLE;
      tx_sh_q <= CG_I;
      mii_tx_take <= 1'b0;
    end else begin
      mii_tx_take <= tx_load_w;
      if (tx_load_w) begin
        tx_st_q <= tx_st_d;
        tx_sh_q <= tx_code_d;
      end else if (tx_tick_w) begin
        tx_sh_q <= {tx_sh_q[3:0], 1'b0};
      end
    end
  end

  // ==========================================================================
  // transmit scrambler, NRZI and MLT-3
  // ==========================================================================
  logic [LFSR_W-1:0] tx_lfsr_q;
  logic tx_key_w;
  logic tx_nrz_w;
  logic tx_nrzi_q;
  logic [1:0] mlt_q;

  assign tx_key_w = tx_lfsr_q[TAP_A] ^ tx_lfsr_q[TAP_B];
  assign tx_nrz_w = tx_sh_q[GROUP_W-1] ^ tx_key_w;

  // a one toggles NRZI; each NRZI toggle steps 0,+,0,- on the line
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_lfsr_q <= LFSR_SEED;
      tx_nrzi_q <= 1'b0;
      mlt_q <= 2'b00;
      line_tx_pos <= 1'b0;
      line_tx_neg <= 1'b0;
    end else if (tx_tick_w) begin
      tx_lfsr_q <= {tx_lfsr_q[LFSR_W-2:0], tx_key_w};
      tx_nrzi_q <= tx_nrzi_q ^ tx_nrz_w;
      if (tx_nrz_w) begin
        mlt_q <= mlt_q + 2'b01;
      end
      line_tx_pos <= (mlt_q + {1'b0, tx_nrz_w}) == 2'b01;
      line_tx_neg <= (mlt_q + {1'b0, tx_nrz_w}) == 2'b11;
    end else if (!active_w) begin
      line_tx_pos <= 1'b0;
      line_tx_neg <= 1'b0;
    end
  end

  // marker runs at bit rate only when the strap enabled it
  always_ff @(posedge clk) begin
    if (rst) begin
      ref_clock_output_pin <= 1'b0;
      mode_mii <= 1'b0;
      mode_nand_tree <= 1'b0;
      mode_power_down <= 1'b0;
      single_indicator_style_strap <= 1'b0;
    end else begin
      ref_clock_output_pin <= tx_sum_w[PH_W] && ref_en_q;
      mode_mii <= (mode_q == MODE_MII);
      mode_nand_tree <= (mode_q == MODE_NAND);
      mode_power_down <= (mode_q == MODE_PDOWN);
      single_indicator_style_strap <= single_led_q;
    end
  end

  // ==========================================================================
  // receive slicer with adaptive threshold
  // ==========================================================================
  logic [SAMPLE_W-1:0] rx_s1_q;
  logic [SAMPLE_W-1:0] rx_s2_q;
  logic [SAMPLE_W-1:0] peak_q;
  logic [SAMPLE_W-1:0] mag_w;
  logic [SAMPLE_W-1:0] thr_w;
  logic signed [SAMPLE_W:0] samp_ext_w;
  logic signed [SAMPLE_W:0] thr_ext_w;
  logic signed [SAMPLE_W:0] diff_w;
  logic lvl_nz_w;
  logic lvl_nz_q;
  logic lvl_prev_q;

  always_ff @(posedge clk) begin
    rx_s1_q <= line_rx_sample;
    rx_s2_q <= rx_s1_q;
  end

  assign mag_w = rx_s2_q[SAMPLE_W-1] ? SAMPLE_W'(-rx_s2_q) : rx_s2_q;
  assign thr_w = peak_q >> 1; // threshold is half the tracked peak
  assign samp_ext_w = {rx_s2_q[SAMPLE_W-1], rx_s2_q};
  assign thr_ext_w = {1'b0, thr_w};
  assign diff_w = $signed({1'b0, mag_w}) - $signed({1'b0, peak_q});
  assign lvl_nz_w = (samp_ext_w > thr_ext_w) || (samp_ext_w < -thr_ext_w);

  // peak follows only symbols above threshold, so zeros do not drag it down
  always_ff @(posedge clk) begin
    if (rst) begin
      peak_q <= SAMPLE_W'(PEAK_INIT);
      lvl_nz_q <= 1'b0;
      lvl_prev_q <= 1'b0;
    end else begin
      if (mag_w > thr_w) begin
        peak_q <= peak_q + SAMPLE_W'(diff_w >>> PEAK_SHIFT);
      end
      lvl_nz_q <= lvl_nz_w; // nonzero level is the NRZI value
      lvl_prev_q <= lvl_nz_q;
    end
  end

  // ==========================================================================
  // receive clock recovery and NRZI to NRZ
  // ==========================================================================
  logic [PH_W-1:0] rx_ph_q;
  logic [PH_W:0] rx_sum_w;
  logic rx_edge_w;
  logic rx_tick_w;
  logic rx_last_q;
  logic rx_nrz_w;
  logic rx_slip_w;
  logic [PH_W-1:0] rx_ph_d;

  assign rx_edge_w = lvl_nz_q != lvl_prev_q;
  assign rx_sum_w = {1'b0, rx_ph_q} + BIT_STEP;
  assign rx_tick_w = rx_sum_w[PH_W] && active_w;
  assign rx_slip_w = rx_edge_w && !rx_sum_w[PH_W]; // edge between ticks: phase is off
  assign rx_ph_d = rx_slip_w ? rx_sum_w[PH_W-1:0] + BIT_STEP[PH_W-1:0] : rx_sum_w[PH_W-1:0];
  assign rx_nrz_w = lvl_nz_q ^ rx_last_q; // a transition is a one

  // an edge must land on a tick, the first clock of a bit; one that does not
  // slips the phase a clock, so sampling settles whatever the cable delay
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_ph_q <= '0;
      rx_last_q <= 1'b0;
    end else begin
      rx_ph_q <= rx_ph_d;
      if (rx_tick_w) begin
        rx_last_q <= lvl_nz_q;
      end
    end
  end

  // ==========================================================================
  // descrambler: locks on idle, which is all ones before scrambling
  // ==========================================================================
  logic [LFSR_W-1:0] rx_lfsr_q;
  logic [5:0] run_q;
  logic rx_key_w;
  logic rx_plain_w;

  assign rx_key_w = rx_lfsr_q[TAP_A] ^ rx_lfsr_q[TAP_B];
  assign rx_plain_w = rx_nrz_w ^ rx_key_w;

  always_ff @(posedge clk) begin
    if (rst || !active_w) begin
      rx_lfsr_q <= LFSR_SEED;
      run_q <= '0;
      rx_locked <= 1'b0;
    end else if (rx_tick_w) begin
      if (rx_locked) begin
        rx_lfsr_q <= {rx_lfsr_q[LFSR_W-2:0], rx_key_w};
      end else begin
        rx_lfsr_q <= {rx_lfsr_q[LFSR_W-2:0], !rx_nrz_w};
        run_q <= (rx_key_w == !rx_nrz_w) ? run_q + 6'h01 : 6'h00;
        rx_locked <= (run_q == LOCK_RUN);
      end
    end
  end

  // ==========================================================================
  // receive alignment, decode and MII nibbles
  // ==========================================================================
  fcp_rx_state_t rx_st_q;
  logic [9:0] win_q;
  logic [9:0] win_d;
  logic [2:0] rx_cnt_q;
  logic pre2_q;
  logic rx_shift_w;
  logic [4:0] dec_w;
  logic grp_end_w;

  assign rx_shift_w = rx_tick_w && rx_locked;
  assign win_d = {win_q[8:0], rx_plain_w};
  assign dec_w = fcp_dec(win_d[4:0]);
  assign grp_end_w = rx_shift_w && (rx_st_q == FCP_RX_FRAME) && (rx_cnt_q == GROUP_LAST);

  // J and K align the groups and stand in for two preamble nibbles
  always_ff @(posedge clk) begin
    if (rst || !active_w) begin
      rx_st_q <= FCP_RX_HUNT;
      win_q <= '0;
      rx_cnt_q <= '0;
      pre2_q <= 1'b0;
    end else begin
      pre2_q <= 1'b0;
      if (rx_shift_w) begin
        win_q <= win_d;
        rx_cnt_q <= (rx_cnt_q == GROUP_LAST) ? 3'h0 : rx_cnt_q + 3'h1;
        case (rx_st_q)
          FCP_RX_HUNT: begin
            if (win_d == {CG_J, CG_K}) begin
              rx_st_q <= FCP_RX_FRAME;
              rx_cnt_q <= '0;
              pre2_q <= 1'b1;
            end
          end
          FCP_RX_FRAME: begin
            if (grp_end_w && (win_d[4:0] == CG_T || win_d[4:0] == CG_I)) begin
              rx_st_q <= FCP_RX_HUNT;
            end
          end
          default: begin
            rx_st_q <= FCP_RX_HUNT;
          end
        endcase
      end
    end
  end

  // nibble output: preamble pair, data, end of stream or bad group
  always_ff @(posedge clk) begin
    if (rst || !active_w) begin
      mii_rx_valid <= 1'b0;
      mii_rx_dv <= 1'b0;
      mii_rxd <= '0;
      mii_rx_er <= 1'b0;
    end else begin
      mii_rx_valid <= 1'b0;
      if (pre2_q || (rx_shift_w && rx_st_q == FCP_RX_HUNT && win_d == {CG_J, CG_K})) begin
        mii_rx_valid <= 1'b1;
        mii_rx_dv <= 1'b1;
        mii_rxd <= PREAMBLE_NIB;
        mii_rx_er <= 1'b0;
      end else if (grp_end_w) begin
        mii_rx_valid <= 1'b1;
        if (win_d[4:0] == CG_T) begin
          mii_rx_dv <= 1'b0;
          mii_rxd <= '0;
          mii_rx_er <= 1'b0;
        end else if (win_d[4:0] == CG_I) begin
          mii_rx_dv <= 1'b0; // idle before T: stream cut short
          mii_rxd <= '0;
          mii_rx_er <= 1'b1;
        end else begin
          mii_rx_dv <= 1'b1;
          mii_rxd <= dec_w[3:0];
          mii_rx_er <= !dec_w[4]; // invalid code group
        end
      end
    end
  end

endmodule // fcp_coding_path

// >>> src/fcp_pkg.sv
// shared constants, code groups and types of the 100 Mb/s coding path
package fcp_pkg;

  // ==========================================================================
  // clocking: bit enables come from a phase accumulator on the system clock
  // ==========================================================================
  localparam int CLK_MHZ = 200;
  localparam int LINE_MHZ = 125;
  localparam int PH_W = 3;
  localparam int PH_MOD = 8;
  localparam logic [PH_W:0] BIT_STEP = (PH_W + 1)'(LINE_MHZ * PH_MOD / CLK_MHZ);
  localparam logic [PH_W-1:0] RX_PHASE_CENTER = 3'h4;

  // ==========================================================================
  // code groups, leftmost bit goes out first
  // ==========================================================================
  localparam int GROUP_W = 5;
  localparam logic [2:0] GROUP_LAST = 3'h4;
  localparam logic [4:0] CG_J = 5'h18;
  localparam logic [4:0] CG_K = 5'h11;
  localparam logic [4:0] CG_T = 5'h0D;
  localparam logic [4:0] CG_R = 5'h07;
  localparam logic [4:0] CG_H = 5'h04;
  localparam logic [4:0] CG_I = 5'h1F;
  localparam logic [3:0] PREAMBLE_NIB = 4'h5;

  // ==========================================================================
  // operating mode strap codes
  // ==========================================================================
  localparam logic [3:0] MODE_MII = 4'h1;
  localparam logic [3:0] MODE_NAND = 4'h4;
  localparam logic [3:0] MODE_PDOWN = 4'h7;
  localparam logic [3:0] MODE_RESET = 4'h0;

  // ==========================================================================
  // scrambler: x^11 + x^9 + 1
  // ==========================================================================
  localparam int LFSR_W = 11;
  localparam int TAP_A = 10;
  localparam int TAP_B = 8;
  localparam logic [LFSR_W-1:0] LFSR_SEED = 11'h7FF;
  localparam logic [5:0] LOCK_RUN = 6'h1E;

  // ==========================================================================
  // adaptive slicer
  // ==========================================================================
  localparam logic [7:0] PEAK_INIT = 8'h40;
  localparam int PEAK_SHIFT = 3;

  typedef enum logic [1:0] {
    FCP_TX_IDLE = 2'b00,
    FCP_TX_K = 2'b01,
    FCP_TX_DATA = 2'b11,
    FCP_TX_R = 2'b10
  } fcp_tx_state_t;

  typedef enum logic {
    FCP_RX_HUNT = 1'b0,
    FCP_RX_FRAME = 1'b1
  } fcp_rx_state_t;

  // data nibble to code group
  function automatic logic [4:0] fcp_enc(input logic [3:0] nib);
    logic [4:0] c;
    case (nib)
      4'h0: c = 5'h1E;
      4'h1: c = 5'h09;
      4'h2: c = 5'h14;
      4'h3: c = 5'h15;
      4'h4: c = 5'h0A;
      4'h5: c = 5'h0B;
      4'h6: c = 5'h0E;
      4'h7: c = 5'h0F;
      4'h8: c = 5'h12;
      4'h9: c = 5'h13;
      4'hA: c = 5'h16;
      4'hB: c = 5'h17;
      4'hC: c = 5'h1A;
      4'hD: c = 5'h1B;
      4'hE: c = 5'h1C;
      default: c = 5'h1D;
    endcase
    return c;
  endfunction

  // code group to {valid, nibble}
  function automatic logic [4:0] fcp_dec(input logic [4:0] cg);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < 16; i++) begin
      if (fcp_enc(4'(i)) == cg) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction

endpackage

// >>> verification/fcp_coding_path_tb.sv
// self-checking bench: strap capture and loop-back frames
`timescale 1ns/10ps
module fcp_coding_path_tb
  import fcp_pkg::*;
();
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] mode_strap = MODE_MII;
  logic ref_clock_output_strap = 1'b1;
  logic indicator_style_strap = 1'b0;
  logic mii_tx_en = 1'b0;
  logic [3:0] mii_txd = 4'h0;
  logic mii_tx_er = 1'b0;
  logic slow = 1'b0;
  logic [7:0] line_rx_sample;
  logic mii_tx_take, mii_rx_valid, mii_rx_dv, mii_rx_er, line_tx_pos, line_tx_neg;
  logic ref_clock_output_pin, mode_mii, mode_nand_tree, mode_power_down;
  logic single_indicator_style_strap, rx_locked;
  logic [3:0] mii_rxd;
  int n_fail = 0;
  int cmp_count = 0;
  int seed = 49641;
  int cyc = 0;
  logic [6:0] exp_q [$]; // {check nibble, dv, er, nibble}
  fcp_coding_path i_dut (.clk(clk), .rst(rst), .mode_strap(mode_strap),
    .ref_clock_output_strap(ref_clock_output_strap),
    .indicator_style_strap(indicator_style_strap), .mii_tx_en(mii_tx_en),
    .mii_txd(mii_txd), .mii_tx_er(mii_tx_er), .line_rx_sample(line_rx_sample),
    .mii_tx_take(mii_tx_take), .mii_rx_valid(mii_rx_valid), .mii_rx_dv(mii_rx_dv),
    .mii_rxd(mii_rxd), .mii_rx_er(mii_rx_er), .line_tx_pos(line_tx_pos),
    .line_tx_neg(line_tx_neg), .ref_clock_output_pin(ref_clock_output_pin),
    .mode_mii(mode_mii), .mode_nand_tree(mode_nand_tree),
    .mode_power_down(mode_power_down), .single_indicator_style_strap(single_indicator_style_strap),
    .rx_locked(rx_locked));
  fcp_line_partner i_line (.clk(clk), .line_tx_pos(line_tx_pos),
    .line_tx_neg(line_tx_neg), .slow(slow), .line_rx_sample(line_rx_sample));
  // ==========================================================================
  // clock, timeout, verdict
  // ==========================================================================
  initial begin
    forever #2.5 clk = ~clk;
  end
  task automatic close_out();
    if (n_fail == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // whole run is a few thousand cycles; ceiling leaves wide margin
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      $display("BAD %0t timeout", $time);
      close_out();
    end
  end
  // ==========================================================================
  // compare tasks
  // ==========================================================================
  task automatic cmp_cfg(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic cmp_rx(input logic [6:0] e);
    logic [5:0] got;
    got = {mii_rx_dv, mii_rx_er, e[6] ? mii_rxd : 4'h0};
    cmp_count++;
    if (got !== e[5:0]) begin
      n_fail++;
      $display("BAD %0t rx got %h exp %h", $time, got, e[5:0]);
    end
  endtask
  // every rx nibble is matched against the model queue
  always @(posedge clk) begin
    if (rst === 1'b0 && mii_rx_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_fail++;
        $display("BAD %0t unexpected rx nibble", $time);
      end else begin
        cmp_rx(exp_q.pop_front());
      end
    end
  end
  // ==========================================================================
  // drivers
  // ==========================================================================
  task automatic do_reset(input logic [3:0] m, input logic r, input logic l);
    @(posedge clk);
    rst <= 1'b1;
    mode_strap <= m; // held across the release edge
    ref_clock_output_strap <= r;
    indicator_style_strap <= l;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
  endtask
  task automatic wait_take();
    int k;
    k = 0;
    @(posedge clk);
    while (mii_tx_take !== 1'b1 && k < 40) begin
      @(posedge clk);
      k++;
    end
    if (k == 40) begin
      n_fail++;
      $display("BAD %0t no take", $time);
    end
  endtask
  // first two nibbles become the start delimiters, seen back as preamble
  task automatic send_frame(input int n);
    logic [3:0] nib;
    logic bad;
    wait_take();
    mii_tx_en <= 1'b1;
    mii_txd <= PREAMBLE_NIB;
    exp_q.push_back({3'b110, PREAMBLE_NIB});
    exp_q.push_back({3'b110, PREAMBLE_NIB});
    for (int i = 1; i < n; i++) begin
      wait_take();
      nib = 4'($random(seed));
      bad = (i > 1) && (($random(seed) & 7) == 0);
      mii_txd <= (i == 1) ? PREAMBLE_NIB : nib;
      mii_tx_er <= bad; // error group decodes as invalid
      if (i > 1) begin
        exp_q.push_back(bad ? 7'h70 : {3'b110, nib});
      end
    end
    wait_take();
    mii_tx_en <= 1'b0;
    mii_tx_er <= 1'b0;
    exp_q.push_back(7'h00);
  endtask
  // ==========================================================================
  // main sequence
  // ==========================================================================
  initial begin
    logic r;
    logic l;
    logic [7:0] cnt;
    logic [7:0] tk;
    int k;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    // every mode code, random ref and led straps
    for (int m = 0; m < 16; m++) begin
      r = 1'($random(seed));
      l = 1'($random(seed));
      do_reset(4'(m), r, l);
      repeat (8) @(posedge clk);
      cnt = 8'h00;
      tk = 8'h00;
      repeat (16) begin
        @(posedge clk);
        cnt = cnt + 8'(ref_clock_output_pin);
        tk = tk + 8'(mii_tx_take);
      end
      cmp_cfg({5'h00, mode_mii, mode_nand_tree, mode_power_down},
        {5'h00, 4'(m) == MODE_MII, 4'(m) == MODE_NAND, 4'(m) == MODE_PDOWN},
        "mode");
      cmp_cfg({7'h00, single_indicator_style_strap}, {7'h00, l}, "led");
      cmp_cfg(cnt, r ? 8'h0A : 8'h00, "ref");
      // 16 clocks hold 10 bit ticks, so exactly two group loads in mii mode
      cmp_cfg(tk, (m == 1) ? 8'h02 : 8'h00, "take");
    end
    // loop-back frames, short strong cable then long weak cable
    for (int sp = 0; sp < 2; sp++) begin
      slow <= sp[0];
      do_reset(MODE_MII, 1'b1, 1'b0);
      k = 0;
      while (rx_locked !== 1'b1 && k < 3000) begin
        @(posedge clk);
        k++;
      end
      cmp_cfg({7'h00, rx_locked}, 8'h01, "lock");
      repeat (6) begin
        send_frame(3 + ($random(seed) & 7));
        k = 0;
        while (exp_q.size() != 0 && k < 400) begin
          @(posedge clk);
          k++;
        end
        cmp_cfg(8'(exp_q.size()), 8'h00, "drain");
        repeat (20) @(posedge clk);
      end
    end
    close_out();
  end
endmodule // fcp_coding_path_tb

bind fcp_coding_path fcp_monitor i_mon (.clk(clk), .rst(rst), .mode_strap(mode_strap),
  .ref_clock_output_strap(ref_clock_output_strap),
  .indicator_style_strap(indicator_style_strap), .mii_tx_take(mii_tx_take),
  .mii_rx_valid(mii_rx_valid), .mii_rx_dv(mii_rx_dv), .mii_rxd(mii_rxd),
  .mii_rx_er(mii_rx_er), .line_tx_pos(line_tx_pos), .line_tx_neg(line_tx_neg),
  .ref_clock_output_pin(ref_clock_output_pin), .mode_mii(mode_mii),
  .mode_nand_tree(mode_nand_tree), .mode_power_down(mode_power_down),
  .single_indicator_style_strap(single_indicator_style_strap), .rx_locked(rx_locked));

// >>> verification/fcp_line_partner.sv
// line model: loops MLT-3 levels back as signed equalised samples
`timescale 1ns/10ps
module fcp_line_partner (
  input wire logic clk, // clock
  input wire logic line_tx_pos, // plus level
  input wire logic line_tx_neg, // minus level
  input wire logic slow, // long cable: delay and weak amplitude
  output logic [7:0] line_rx_sample // equalised sample
);
  logic [7:0] amp;
  logic [7:0] lvl;
  logic [7:0] dly_q [0:3] = '{default: 8'h00};
  // weak level sits just above the starting threshold to force adaptation
  assign amp = slow ? 8'h30 : 8'h64;
  assign lvl = line_tx_pos ? amp : (line_tx_neg ? -amp : 8'h00);
  // cable delay line
  always_ff @(posedge clk) begin
    dly_q[0] <= lvl;
    dly_q[1] <= dly_q[0];
    dly_q[2] <= dly_q[1];
    dly_q[3] <= dly_q[2];
  end
  assign line_rx_sample = slow ? dly_q[3] : dly_q[0];
endmodule // fcp_line_partner

// >>> verification/fcp_monitor.sv
// port checker for the 100 Mb/s coding path
`timescale 1ns/10ps
module fcp_monitor
  import fcp_pkg::*;
(
  input wire logic clk, // clock
  input wire logic rst, // reset
  input wire logic [3:0] mode_strap, // mode pins
  input wire logic ref_clock_output_strap, // ref strap
  input wire logic indicator_style_strap, // led strap
  input wire logic mii_tx_take, // take pulse
  input wire logic mii_rx_valid, // rx pulse
  input wire logic mii_rx_dv, // rx valid
  input wire logic [3:0] mii_rxd, // rx nibble
  input wire logic mii_rx_er, // rx error
  input wire logic line_tx_pos, // plus level
  input wire logic line_tx_neg, // minus level
  input wire logic ref_clock_output_pin, // ref marker
  input wire logic mode_mii, // mii mode
  input wire logic mode_nand_tree, // nand mode
  input wire logic mode_power_down, // off mode
  input wire logic single_indicator_style_strap, // led style
  input wire logic rx_locked // lock
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic last_pos_q;
  logic last_pos_d;
  logic [1:0] rel_q;
  logic [1:0] rel_d;
  logic cfg_ok;
  // ==========================================================================
  // helpers
  // ==========================================================================
  // sign of last nonzero level; cleared so the first step may go positive
  assign last_pos_d = line_tx_pos ? 1'b1 : (line_tx_neg ? 1'b0 : last_pos_q);
  // edges since release; straps are only meaningful once settled
  assign rel_d = (rel_q == 2'h3) ? rel_q : rel_q + 2'h1;
  assign cfg_ok = (rel_q == 2'h3);
  always_ff @(posedge clk) begin
    last_pos_q <= rst ? 1'b0 : last_pos_d;
    rel_q <= rst ? 2'h0 : rel_d;
  end
  // ==========================================================================
  // assertions
  // ==========================================================================
  a_take_one_cycle: assert property (mii_tx_take |=> !mii_tx_take)
    else $error("take pulse too long");
  a_take_group_gap: assert property (mii_tx_take && mode_mii |=>
    !mii_tx_take [*6] ##[1:3] mii_tx_take)
    else $error("take spacing wrong");
  a_mlt_one_level: assert property (!(line_tx_pos && line_tx_neg))
    else $error("both line levels");
  a_mlt_via_zero: assert property (line_tx_pos |=> !line_tx_neg)
    else $error("line jumped plus to minus");
  a_mlt_step_order: assert property ($rose(line_tx_pos) |-> !last_pos_q)
    else $error("two plus steps in a row");
  a_rx_out_hold: assert property (!mii_rx_valid |->
    $stable({mii_rx_dv, mii_rxd, mii_rx_er}))
    else $error("rx outputs moved without valid");
  a_rx_after_lock: assert property (mii_rx_valid |-> rx_locked)
    else $error("rx nibble before lock");
  a_quiet_other_mode: assert property (!mode_mii [*4] |->
    !mii_tx_take && !line_tx_pos && !line_tx_neg && !mii_rx_valid)
    else $error("datapath active outside mii mode");
  a_mode_decode_ok: assert property (cfg_ok |->
    mode_mii == (mode_strap == MODE_MII)
    && mode_nand_tree == (mode_strap == MODE_NAND)
    && mode_power_down == (mode_strap == MODE_PDOWN))
    else $error("mode decode wrong");
  a_led_style_ok: assert property (cfg_ok |-> single_indicator_style_strap == indicator_style_strap)
    else $error("led style wrong");
  a_ref_off_low: assert property (!ref_clock_output_strap |-> !ref_clock_output_pin)
    else $error("ref marker while disabled");
  a_ref_tick_rate: assert property (ref_clock_output_strap && ref_clock_output_pin |->
    ##[1:2] ref_clock_output_pin)
    else $error("ref marker gap too long");
  c_rx_err: cover property (mii_rx_valid && mii_rx_dv && mii_rx_er);
  c_rx_end: cover property (mii_rx_valid && !mii_rx_dv);
  c_nand: cover property (mode_nand_tree);
  c_locked_take: cover property (rx_locked && mii_tx_take);
endmodule // fcp_monitor
